/* rtl/pfc_host.sv */
// host-side controller driving a parallel nor flash through its pins
`timescale 1ns/100ps
`include "pfc_defs.svh"
module pfc_host import pfc_pkg::*; #(
	parameter int unsigned TIMEOUT_CYC = 32'd4000000
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output pfc_pins_t        flash,
	input  wire logic [15:0] flash_dq_in,
	input  wire logic        flash_ready
);
	localparam logic [7:0] WP_CYC  = 8'(`PFC_CYC(`PFC_T_WP_NS));
	localparam logic [7:0] WPH_CYC = 8'(`PFC_CYC(`PFC_T_WPH_NS));
	localparam logic [7:0] ACC_CYC = 8'(`PFC_CYC(`PFC_T_ACC_NS) + 2);
	localparam logic [7:0] RST_CYC = 8'(`PFC_CYC(`PFC_T_RST_NS));
	if (TIMEOUT_CYC < 32'd16) begin : g_chk
		$error("TIMEOUT_CYC too small");
	end

	// ==========================================================
	// command sequence tables
	function automatic logic [2:0] seq_len(input pfc_op_t op, input logic spm);
		case (op)
			PFC_OP_PROG: seq_len = spm ? 3'd1 : 3'd4;
			default:     seq_len = 3'd6;
		endcase
	endfunction

	function automatic pfc_wcyc_t seq(input pfc_op_t op, input logic [2:0] idx,
			input logic [20:0] a, input logic [15:0] d, input logic spm);
		seq = '{addr: `PFC_UNLK1_ADDR, data: {8'h00, `PFC_UNLK1_DATA}};
		if (op == PFC_OP_PROG && spm) begin
			seq = '{addr: a, data: d};
		end else begin
			case (idx)
				3'd1, 3'd4: seq = '{addr: `PFC_UNLK2_ADDR, data: {8'h00, `PFC_UNLK2_DATA}};
				3'd2: case (op)
					PFC_OP_PROG: seq.data = {8'h00, `PFC_CMD_PROG};
					PFC_OP_SPM:  seq.data = {8'h00, `PFC_CMD_SPM_A};
					default:     seq.data = {8'h00, `PFC_CMD_ERASE};
				endcase
				3'd3: if (op == PFC_OP_PROG) begin
					seq = '{addr: a, data: d};
				end
				3'd5: case (op)
					PFC_OP_SECTOR: seq = '{addr: a, data: {8'h00, `PFC_CMD_SECTOR}};
					PFC_OP_SPM:    seq.data = {8'h00, `PFC_CMD_SPM_B};
					default:       seq.data = {8'h00, `PFC_CMD_CHIP};
				endcase
				default: ;
			endcase
		end
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;
	logic        rdy_s1;
	logic        rdy_s2;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1  <= 16'h0000;
			dq_s2  <= 16'h0000;
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
		end else begin
			dq_s1  <= flash_dq_in;
			dq_s2  <= dq_s1;
			rdy_s1 <= flash_ready;
			rdy_s2 <= rdy_s1;
		end
	end

	// ==========================================================
	// register port and access engine
	pfc_core_t   r;
	pfc_core_t   next_r;
	logic [31:0] next_rdata;
	logic        busy;
	logic        byte_mode;
	logic [15:0] val;
	logic        go;
	pfc_wcyc_t   wc;
	pfc_op_t     new_op;

	assign busy      = (r.st != PFC_S_IDLE);
	assign byte_mode = !r.pins.byte_n;
	assign val       = byte_mode ? {8'h00, dq_s2[7:0]} : dq_s2;
	assign go        = reg_wr && reg_addr == `PFC_REG_CTRL && reg_wdata[`PFC_CTRL_GO];
	assign new_op    = pfc_op_t'(reg_wdata[2:0]);
	assign wc        = seq(r.op, r.idx, byte_mode ? r.addr[21:1] : r.addr[20:0], r.data, r.spm);
	assign flash     = r.pins;

	always_comb begin
		next_r     = r;
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`PFC_REG_ADDR: next_rdata = {10'h000, r.addr};
				`PFC_REG_DATA: next_rdata = {16'h0000, r.data};
				`PFC_REG_CTRL: next_rdata = {26'h0, r.spm_ok, r.pins.vpp_en,
					!r.pins.byte_n, r.op};
				`PFC_REG_STAT: next_rdata = {25'h0, rdy_s2, r.spm, r.refused,
					r.tmo_err, r.err, r.done, busy};
				`PFC_REG_RDAT: next_rdata = {16'h0000, r.rd};
				default:       next_rdata = 32'h0000_0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				`PFC_REG_ADDR: next_r.addr = reg_wdata[21:0];
				`PFC_REG_DATA: next_r.data = reg_wdata[15:0];
				`PFC_REG_STAT: begin
					// write-one-to-clear; engine sets below win
					if (reg_wdata[`PFC_ST_DONE]) next_r.done = 1'b0;
					if (reg_wdata[`PFC_ST_ERR]) next_r.err = 1'b0;
					if (reg_wdata[`PFC_ST_TMO]) next_r.tmo_err = 1'b0;
					if (reg_wdata[`PFC_ST_REFUSED]) next_r.refused = 1'b0;
				end
				`PFC_REG_CTRL: if (!busy) begin
					next_r.pins.byte_n = !reg_wdata[`PFC_CTRL_BYTE];
					next_r.pins.vpp_en = reg_wdata[`PFC_CTRL_VPP];
					next_r.spm_ok      = reg_wdata[`PFC_CTRL_SPMOK];
				end
				default: ;
			endcase
		end
		if (go) begin
			if (busy) begin
				next_r.refused = 1'b1;
			end else if (new_op > PFC_OP_RESET
					|| (new_op != PFC_OP_READ && new_op != PFC_OP_RESET
						&& !reg_wdata[`PFC_CTRL_VPP])
					|| (r.spm && (new_op == PFC_OP_SECTOR || new_op == PFC_OP_CHIP))
					|| (new_op == PFC_OP_SPM && !reg_wdata[`PFC_CTRL_SPMOK])) begin
				next_r.refused = 1'b1;
			end else begin
				next_r.op      = new_op;
				next_r.idx     = 3'd0;
				next_r.done    = 1'b0;
				next_r.err     = 1'b0;
				next_r.tmo_err = 1'b0;
				next_r.tmo     = 32'd0;
				next_r.first   = 1'b1;
				case (new_op)
					PFC_OP_READ: next_r.st = PFC_S_RSET;
					PFC_OP_RESET: begin
						next_r.st           = PFC_S_RST;
						next_r.cnt          = RST_CYC - 8'd1;
						next_r.pins.reset_n = 1'b0;
					end
					default: next_r.st = PFC_S_WSET;
				endcase
			end
		end
		case (r.st)
			PFC_S_IDLE: ;
			PFC_S_WSET: begin
				next_r.pins.addr   = wc.addr;
				next_r.pins.dq_out = byte_mode ? {r.addr[0], 7'h00, wc.data[7:0]} : wc.data;
				next_r.pins.dq_oe  = byte_mode ? 16'h80FF : 16'hFFFF;
				next_r.pins.ce_n   = 1'b0;
				next_r.pins.oe_n   = 1'b1;
				next_r.pins.we_n   = 1'b0;
				next_r.cnt         = WP_CYC - 8'd1;
				next_r.st          = PFC_S_WLOW;
			end
			PFC_S_WLOW: if (r.cnt == 8'd0) begin
				next_r.pins.we_n = 1'b1; // data latched on this rising edge
				next_r.cnt       = WPH_CYC - 8'd1;
				next_r.st        = PFC_S_WHI;
			end else begin
				next_r.cnt = r.cnt - 8'd1;
			end
			PFC_S_WHI: if (r.cnt == 8'd0) begin
				next_r.pins.ce_n  = 1'b1;
				next_r.pins.dq_oe = 16'h0000;
				if (r.idx == seq_len(r.op, r.spm) - 3'd1) begin
					if (r.op == PFC_OP_SPM) begin
						next_r.spm  = 1'b1;
						next_r.done = 1'b1;
						next_r.st   = PFC_S_IDLE;
					end else begin
						next_r.st = PFC_S_RSET; // wait for the self-timed cycle
					end
				end else begin
					next_r.idx = r.idx + 3'd1;
					next_r.st  = PFC_S_WSET;
				end
			end else begin
				next_r.cnt = r.cnt - 8'd1;
			end
			PFC_S_RSET: begin
				next_r.pins.addr   = byte_mode ? r.addr[21:1] : r.addr[20:0];
				next_r.pins.dq_out = {r.addr[0], 15'h0000};
				next_r.pins.dq_oe  = byte_mode ? 16'h8000 : 16'h0000;
				next_r.pins.ce_n   = 1'b0;
				next_r.pins.oe_n   = 1'b0;
				next_r.cnt         = ACC_CYC;
				next_r.st          = PFC_S_RCAP;
			end
			PFC_S_RCAP: if (r.cnt == 8'd0) begin
				next_r.pins.ce_n = 1'b1;
				next_r.pins.oe_n = 1'b1; // oe high between reads lets line six toggle
				next_r.rd        = val;
				next_r.first     = 1'b0;
				next_r.last6     = val[6];
				if (r.op == PFC_OP_READ) begin
					next_r.done = 1'b1;
					next_r.st   = PFC_S_IDLE;
				end else if (!r.first && r.last6 == val[6] && rdy_s2) begin
					next_r.done = 1'b1;
					next_r.st   = PFC_S_IDLE;
				end else if (!r.first && r.last6 != val[6] && val[5] && r.rd[5]) begin
					next_r.err = 1'b1; // dq5 on two reads in a row
					next_r.st  = PFC_S_IDLE;
				end else begin
					next_r.st = PFC_S_RSET;
				end
			end else begin
				next_r.cnt = r.cnt - 8'd1;
			end
			PFC_S_RST: if (r.cnt == 8'd0) begin
				next_r.pins.reset_n = 1'b1;
				next_r.spm          = 1'b0;
				next_r.done         = 1'b1;
				next_r.st           = PFC_S_IDLE;
			end else begin
				next_r.cnt = r.cnt - 8'd1;
			end
			default: next_r.st = PFC_S_IDLE;
		endcase
		if (r.st == PFC_S_RSET || r.st == PFC_S_RCAP) begin
			next_r.tmo = r.tmo + 32'd1;
			// erase of a large array can exceed any guess; software may retry
			if (r.op != PFC_OP_READ && r.tmo == TIMEOUT_CYC - 32'd1) begin
				next_r.tmo_err   = 1'b1;
				next_r.pins.ce_n = 1'b1;
				next_r.pins.oe_n = 1'b1;
				next_r.st        = PFC_S_IDLE;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r                <= '0;
			r.pins.ce_n      <= 1'b1;
			r.pins.oe_n      <= 1'b1;
			r.pins.we_n      <= 1'b1;
			r.pins.reset_n   <= 1'b1;
			r.pins.byte_n    <= 1'b1;
			reg_rdata        <= 32'h0000_0000;
		end else begin
			r         <= next_r;
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [7:0] low_run;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) low_run <= 8'h00;
		else low_run <= flash.reset_n ? 8'h00 : low_run + 8'h01;
	end
	property p_we_oe; !flash.we_n |-> flash.oe_n && !flash.ce_n; endproperty
	a_we_oe: assert property (p_we_oe) else $error("write pulse without ce low, oe high");
	property p_we_len; $fell(flash.we_n) |-> !flash.we_n[*3] ##1 flash.we_n; endproperty
	a_we_len: assert property (p_we_len) else $error("write pulse width wrong");
	property p_read; !flash.oe_n |-> flash.we_n && flash.dq_oe[14:0] == 15'h0000; endproperty
	a_read: assert property (p_read) else $error("data driven during read");
	property p_byte; !flash.byte_n |-> flash.dq_oe[14:8] == 7'h00; endproperty
	a_byte: assert property (p_byte) else $error("lines 8-14 driven in byte mode");
	property p_rst_len; $rose(flash.reset_n) |-> $past(low_run) >= RST_CYC - 8'd1; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
	property p_spm_exit; $rose(flash.reset_n) |-> !r.spm; endproperty
	a_spm_exit: assert property (p_spm_exit) else $error("single pulse mode kept over reset");
	property p_vpp; $fell(flash.we_n) |-> flash.vpp_en; endproperty
	a_vpp: assert property (p_vpp) else $error("write with protect supply off");
	property p_refuse; go && busy |=> r.refused && $stable(r.op); endproperty
	a_refuse: assert property (p_refuse) else $error("command accepted while busy");
	property p_done; $rose(r.done) |-> $past(r.st) inside {PFC_S_RCAP, PFC_S_RST, PFC_S_WHI};
	endproperty
	a_done: assert property (p_done) else $error("done from wrong state");
	property p_rdata; reg_rd && reg_addr == `PFC_REG_RDAT |=> reg_rdata[15:0] == $past(r.rd);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data mismatch");
	c_prog:   cover property (r.op == PFC_OP_PROG && $rose(r.done));
	c_sector: cover property (r.op == PFC_OP_SECTOR && $rose(r.done));
	c_spm:    cover property ($rose(r.spm));
	c_err:    cover property ($rose(r.err));
endmodule

/* rtl/pfc_defs.svh */
// constants of the parallel flash command controller
// Notes on behaviour
// - after six-cycle entry, each single write pulse programs data directly.
// - single-pulse mode ends on power loss or reset low 500 ns then high.
// - single-pulse entry recommended only from production programming equipment.
// - write pulse with other strobe low, output enable high; address late, data early.
// - four-cycle sequence programs one byte or word, self-timed by the device.
// - 71 sectors; sixth cycle latches sector address and code 30H.
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
`define PFC_REG_ADDR    8'h00
`define PFC_REG_DATA    8'h04
`define PFC_REG_CTRL    8'h08
`define PFC_REG_STAT    8'h0C
`define PFC_REG_RDAT    8'h10
`define PFC_CTRL_BYTE   3
`define PFC_CTRL_VPP    4
`define PFC_CTRL_SPMOK  5
`define PFC_CTRL_GO     7
`define PFC_ST_BUSY     0
`define PFC_ST_DONE     1
`define PFC_ST_ERR      2
`define PFC_ST_TMO      3
`define PFC_ST_REFUSED  4
`define PFC_ST_SPM      5
`define PFC_ST_RDY      6
`define PFC_CLK_NS      25
`define PFC_T_WP_NS     70
`define PFC_T_WPH_NS    50
`define PFC_T_ACC_NS    100
`define PFC_T_RST_NS    500
`define PFC_CYC(ns)     (((ns) + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_UNLK1_ADDR  21'h000555
`define PFC_UNLK2_ADDR  21'h0002AA
`define PFC_UNLK1_DATA  8'hAA
`define PFC_UNLK2_DATA  8'h55
`define PFC_CMD_PROG    8'hA0
`define PFC_CMD_ERASE   8'h80
`define PFC_CMD_CHIP    8'h10
`define PFC_CMD_SECTOR  8'h30
`define PFC_CMD_SPM_A   8'h80
`define PFC_CMD_SPM_B   8'hA0
`define PFC_SECTORS     71
`endif

/* rtl/pfc_pkg.sv */
// types of the parallel flash command controller
package pfc_pkg;
	typedef enum logic [2:0] {
		PFC_S_IDLE = 3'b000,
		PFC_S_WSET = 3'b001,
		PFC_S_WLOW = 3'b010,
		PFC_S_WHI  = 3'b011,
		PFC_S_RSET = 3'b100,
		PFC_S_RCAP = 3'b101,
		PFC_S_RST  = 3'b110
	} pfc_state_t;
	typedef enum logic [2:0] {
		PFC_OP_READ   = 3'b000,
		PFC_OP_PROG   = 3'b001,
		PFC_OP_SECTOR = 3'b010,
		PFC_OP_CHIP   = 3'b011,
		PFC_OP_SPM    = 3'b100,
		PFC_OP_RESET  = 3'b101
	} pfc_op_t;
	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] dq_out;
		logic [15:0] dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        reset_n;
		logic        byte_n;
		logic        vpp_en;
	} pfc_pins_t;
	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] data;
	} pfc_wcyc_t;
	typedef struct packed {
		pfc_state_t  st;
		pfc_op_t     op;
		logic [2:0]  idx;
		logic [7:0]  cnt;
		logic [31:0] tmo;
		logic        first;
		logic        last6;
		logic [21:0] addr;
		logic [15:0] data;
		logic [15:0] rd;
		logic        spm_ok;
		logic        spm;
		logic        done;
		logic        err;
		logic        tmo_err;
		logic        refused;
		pfc_pins_t   pins;
	} pfc_core_t;
endpackage

/* bench/pfc_flash_model.sv */
// behavioural model of the parallel nor flash device
`timescale 1ns/100ps
module pfc_flash_model import pfc_pkg::*; #(
	parameter int PROG_NS  = 2000,
	parameter int ERASE_NS = 5000,
	parameter int LOCKED_SECTOR = 3
) (
	input  pfc_pins_t        pins,
	input  wire logic [15:0] dq,
	output logic      [15:0] dev_dq,
	output logic      [15:0] dev_oe,
	output logic             ready
);
	logic [15:0] mem [16];
	logic [47:0] hist;
	logic [15:0] rword;
	logic        busy, armed, spm, tog, pb7, rd_on, fail;
	logic [3:0]  pa;
	int          dur;
	realtime     t_low;
	// power-up lands in read mode with an erased array
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{busy, armed, spm, tog, pb7, fail, hist} = '0;
		dur = 0;
		t_low = 0.0;
	end
	assign ready  = ~busy;
	assign rd_on  = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_n;
	// status word while busy: complement on line 7, toggle on 6, line 5 low
	// failed erase: line 5 high and line 6 toggling until a reset
	assign rword  = fail ? {9'h000, tog, 6'h20} : busy ? {8'h00, ~pb7, tog, 6'h00}
		: mem[pins.addr[3:0]];
	assign dev_oe = !rd_on ? 16'h0000 : pins.byte_n ? 16'hFFFF : 16'h00FF;
	assign dev_dq = !pins.byte_n ? {8'h00, dq[15] ? rword[15:8] : rword[7:0]} : rword;
	always @(negedge rd_on)
		if (busy || fail) tog = ~tog;
	always begin : tmr
		@(posedge busy);
		#(dur);
		busy = 1'b0;
	end
	task automatic erase(input int base, input int n);
		// a locked sector keeps its contents through a chip erase
		for (int i = base; i < base + n; i++)
			if (i / 4 != LOCKED_SECTOR) mem[i] = 16'hFFFF;
		dur = ERASE_NS;
		busy = 1'b1;
	endtask
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.reset_n && !busy) begin
			if (spm || armed) begin
				armed = 1'b0;
				if (pins.vpp_en) begin
					// byte mode: line 15 picks the lane, the other lane is left alone
					mem[pins.addr[3:0]] &= pins.byte_n ? dq
						: dq[15] ? {dq[7:0], 8'hFF} : {8'hFF, dq[7:0]};
					pa = pins.addr[3:0];
					pb7 = dq[7];
					dur = PROG_NS;
					busy = 1'b1;
				end
			end else begin
				// command cycles shift history; only a completed chip or sector erase sequence touches the array
				hist = {hist[39:0], dq[7:0]};
				if (hist[47:8] == 40'hAA5580AA55) begin
					if (hist[7:0] == 8'hA0) spm = 1'b1;
					else if (pins.vpp_en && hist[7:0] == 8'h10) erase(0, 16);
					else if (pins.vpp_en && hist[7:0] == 8'h30
							&& pins.addr[3:2] == LOCKED_SECTOR)
						fail = 1'b1;
					else if (pins.vpp_en && hist[7:0] == 8'h30)
						erase({pins.addr[3:2], 2'b00}, 4);
					hist = '0;
				end else if (hist[23:0] == 24'hAA55A0) begin
					armed = 1'b1;
					hist = '0;
				end
			end
		end
	end
	always @(negedge pins.reset_n) begin
		t_low = $realtime;
		if (busy && dur == PROG_NS) mem[pa] = 'x;
		disable tmr;
		{busy, armed, hist, fail} = '0;
	end
	always @(posedge pins.reset_n)
		if ($realtime - t_low >= 500.0) spm = 1'b0;
endmodule

/* bench/pfc_host_test.sv */
// self-checking bench of the parallel flash host controller
`timescale 1ns/100ps
`include "pfc_defs.svh"
module pfc_host_test import pfc_pkg::*;;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	pfc_pins_t   flash;
	logic [15:0] dq_in, dev_dq, dev_oe;
	logic [15:0] noise = 16'h5A5A;
	logic        flash_ready, saw_busy;
	int          mismatches = 0;
	int          num_checks = 0;
	int          nwe = 0;
	always #12.5 mclk = ~mclk;
	// undriven lines show a changing pattern so stale data cannot pass
	always @(posedge mclk) noise <= ~noise;
	assign dq_in = (flash.dq_oe & flash.dq_out) | (~flash.dq_oe & dev_oe & dev_dq)
		| (~flash.dq_oe & ~dev_oe & noise);
	always @(negedge flash.we_n) nwe++;
	pfc_host #(.TIMEOUT_CYC(2000)) i_dut (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_rdata  (reg_rdata),
		.flash      (flash),
		.flash_dq_in(dq_in),
		.flash_ready(flash_ready)
	);
	pfc_flash_model i_flash (
		.pins  (flash),
		.dq    (dq_in),
		.dev_dq(dev_dq),
		.dev_oe(dev_oe),
		.ready (flash_ready)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge mclk);
	endtask
	// cfg is {single-pulse allowed, supply enable, byte mode}
	task automatic op(input logic [2:0] o, input logic [2:0] cfg, input logic [21:0] a,
			input logic [15:0] d, output logic [31:0] s);
		wr(`PFC_REG_ADDR, {10'h000, a});
		wr(`PFC_REG_DATA, {16'h0000, d});
		wr(`PFC_REG_CTRL, {24'h000000, 2'b10, cfg, o});
		s = 32'h0;
		for (int n = 0; n < 3000 && s[4:1] === 4'h0; n++) begin
			if (flash_ready === 1'b0) saw_busy = 1'b1;
			rd(`PFC_REG_STAT, s);
		end
		check({31'h0, s[4:1] !== 4'h0}, 32'h1);
		wr(`PFC_REG_STAT, 32'h0000001E);
	endtask
	task automatic rdf(input logic [2:0] cfg, input logic [21:0] a, output logic [31:0] v);
		logic [31:0] s;
		op(3'd0, cfg, a, 16'h0000, s);
		rd(`PFC_REG_RDAT, v);
	endtask
	task automatic t_pins;
		check({28'h0, flash.ce_n, flash.oe_n, flash.we_n, flash.reset_n}, 32'hF);
		check({16'h0, flash.dq_oe}, 32'h0);
		$display("test pins done");
	endtask
	task automatic t_prog;
		logic [31:0] s, v;
		int n0;
		n0 = nwe;
		saw_busy = 1'b0;
		op(3'd1, 3'b010, 22'h3, 16'h1234, s);
		check(s[4:1], 4'h1);
		check(32'(nwe - n0), 32'd4);
		check(saw_busy, 1'b1);
		rdf(3'b010, 22'h3, v);
		check(v, 32'h1234);
		op(3'd1, 3'b010, 22'h3, 16'hFF00, s);
		rdf(3'b010, 22'h3, v);
		check(v, 32'h1200);
		n0 = nwe;
		op(3'd1, 3'b000, 22'h3, 16'h0000, s);
		check(s[4:1], 4'h8);
		check(32'(nwe - n0), 32'd0);
		$display("test program done");
	endtask
	task automatic t_erase;
		logic [31:0] s, v;
		int n0;
		n0 = nwe;
		op(3'd2, 3'b010, 22'h0, 16'h0000, s);
		check(s[4:1], 4'h1);
		check(32'(nwe - n0), 32'd6);
		rdf(3'b010, 22'h3, v);
		check(v, 32'hFFFF);
		// second launch while the first erase runs must be turned away
		wr(`PFC_REG_CTRL, 32'h00000092);
		wr(`PFC_REG_CTRL, 32'h00000091);
		rd(`PFC_REG_STAT, s);
		check(s[4:0], 5'h11);
		for (int n = 0; n < 500 && s[1] !== 1'b1; n++)
			rd(`PFC_REG_STAT, s);
		check(s[4:0], 5'h12);
		wr(`PFC_REG_STAT, 32'h0000001E);
		op(3'd1, 3'b010, 22'h9, 16'h0000, s);
		rdf(3'b010, 22'h9, v);
		check(v, 32'h0000);
		op(3'd1, 3'b010, 22'hC, 16'h1234, s);
		op(3'd2, 3'b010, 22'hC, 16'h0000, s);
		check(s[4:1], 4'h2);
		op(3'd5, 3'b010, 22'h0, 16'h0000, s);
		rdf(3'b010, 22'hC, v);
		check(v, 32'h1234);
		op(3'd3, 3'b010, 22'h0, 16'h0000, s);
		check(s[4:1], 4'h1);
		rdf(3'b010, 22'h9, v);
		check(v, 32'hFFFF);
		rdf(3'b010, 22'hC, v);
		check(v, 32'h1234);
		$display("test erase done");
	endtask
	task automatic t_byte;
		logic [31:0] s, v;
		op(3'd1, 3'b010, 22'h5, 16'hABCD, s);
		rdf(3'b010, 22'h5, v);
		check(v, 32'hABCD);
		rdf(3'b001, 22'hB, v);
		check(v, 32'hAB);
		rdf(3'b001, 22'hA, v);
		check(v, 32'hCD);
		op(3'd1, 3'b011, 22'hA, 16'h0001, s);
		rdf(3'b010, 22'h5, v);
		check(v, 32'hAB01);
		$display("test byte done");
	endtask
	task automatic t_spm;
		logic [31:0] s, v;
		int n0;
		op(3'd4, 3'b010, 22'h0, 16'h0000, s);
		check(s[4:1], 4'h8);
		op(3'd4, 3'b110, 22'h0, 16'h0000, s);
		check(s[5:1], 5'h11);
		n0 = nwe;
		op(3'd1, 3'b110, 22'h7, 16'h5A5A, s);
		check(32'(nwe - n0), 32'd1);
		rdf(3'b110, 22'h7, v);
		check(v, 32'h5A5A);
		op(3'd2, 3'b110, 22'h4, 16'h0000, s);
		check(s[4:1], 4'h8);
		op(3'd5, 3'b110, 22'h0, 16'h0000, s);
		check(s[5], 1'b0);
		op(3'd1, 3'b110, 22'h7, 16'h0F0F, s);
		rdf(3'b110, 22'h7, v);
		check(v, 32'h0A0A);
		rdf(3'b010, 22'h5, v);
		check(v, 32'hAB01);
		$display("test single pulse done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		// the tests need well under ten thousand cycles
		repeat (40000) @(posedge mclk);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_pins();
		t_prog();
		t_erase();
		t_byte();
		t_spm();
		wrap_up();
	end
endmodule
